// File: design/gpb_bank.v
`timescale 1ns/1ps
`include "gpb_regs.vh"
// Notes on behaviour
// - Function-select bit 0 turns input 0 into bus request A and output 16 into grant A.
// - Input 1 is bus request B when selected, or request 5 when general-control bit 25 is also set.
// - Function-select bits 2 to 5 turn inputs 2 to 5 into shared interrupt lines E to H.
// - Each implemented input-only pin shows its status in the event status bit of the same number.
// - Function-select bit 11 turns input 11 into the bus alert input.
// - Outputs 16 and 17 drive pin level bits 16 and 17 unless in their grant function.
// - Bidirectional pin 25 blinks its output while blink bit 25 and pin level bit 25 are both set.
// - Pin level bits 25, 27 and 28 drive the output and read back the sampled pin.
// - After reset every shared pin sits in its alternate function.
// - A status bit is set after two consecutive active samples and stays until cleared.
// - Inputs are sampled at the bus rate when awake and at the real-time rate in sleep.
// - A status bit cleared while its input is still active sets again with no new edge.
// - Pins 0 to 15 route to the management interrupt, the configuration interrupt, or neither.
module gpb_bank #(
    parameter BLINK_TICKS = `GPB_BLINK_RTC_TICKS
) (
    // clock and reset
    input  wire        ref_clk,
    input  wire        reset_n,
    // register port
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output wire [31:0] reg_rdata,
    // power state, high while in a sleep state
    input  wire        sleep_state,
    // input-only pins 0..13, position = pin number
    input  wire [13:0] gpi_pin,
    // output-only pins 16 and 17
    output wire [1:0]  gpo_pin,
    // bidirectional pins 25, 27, 28 (index 0, 1, 2)
    input  wire [2:0]  gpio_in,
    output wire [2:0]  gpio_out,
    output wire [2:0]  gpio_oe,
    // alternate functions towards the arbiter and interrupt logic
    output wire        bus_req_a_n,
    output wire        bus_req_b_n,
    output wire        bus_req_5_n,
    input  wire        bus_grant_a_n,
    input  wire        bus_grant_b_n,
    input  wire        bus_grant_5_n,
    output wire [3:0]  shared_interrupt_e_to_h_n,
    output wire        bus_alert_n,
    // interrupts
    output wire        management_interrupt,
    output wire        configuration_interrupt,
    output wire        irq
);

    // sampling dividers, rounded down so sampling is never slower than stated
    localparam integer BUS_DIV_I = `GPB_CLK_HZ / `GPB_BUS_SAMPLE_HZ;
    localparam integer RTC_DIV_I = `GPB_CLK_HZ / `GPB_RTC_SAMPLE_HZ;
    localparam [11:0]  BUS_DIV   = BUS_DIV_I[11:0];
    localparam [11:0]  RTC_DIV   = RTC_DIV_I[11:0];
    localparam integer BLINK_MAX_I = BLINK_TICKS - 1;
    localparam [15:0]  BLINK_MAX = BLINK_MAX_I[15:0];

    reg  [31:0] func_select_ff;
    reg  [31:0] gen_control_ff;
    reg  [31:0] polarity_ff;
    reg  [31:0] status_ff;
    reg  [31:0] level_ff;
    reg  [31:0] blink_ff;
    reg  [31:0] io_dir_ff;
    reg  [31:0] route_ff;
    reg  [31:0] irq_mask_ff;
    reg  [31:0] rdata_ff;
    reg  [31:0] nxt_rdata;
    reg  [31:0] nxt_status;
    reg  [11:0] bus_cnt_ff;
    reg  [11:0] rtc_cnt_ff;
    reg  [15:0] blink_cnt_ff;
    reg         blink_phase_ff;
    reg  [13:0] gpi_meta_ff;
    reg  [13:0] gpi_sync_ff;
    reg  [2:0]  gpio_meta_ff;
    reg  [2:0]  gpio_sync_ff;
    wire        bus_tick;
    wire        rtc_tick;
    wire        sample_en;
    wire [13:0] qualified;
    wire [31:0] set_vec;
    wire [31:0] level_rd;
    wire [15:0] mgmt_vec;
    wire [15:0] cfg_vec;
    wire        wr_sel;
    wire        wr_gc;
    wire        wr_pol;
    wire        wr_sts;
    wire        wr_lvl;
    wire        wr_blk;
    wire        wr_dir;
    wire        wr_route;
    wire        wr_mask;

    // two-flop synchronisers for every pin input
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            gpi_meta_ff  <= 14'h0000;
            gpi_sync_ff  <= 14'h0000;
            gpio_meta_ff <= 3'h0;
            gpio_sync_ff <= 3'h0;
        end else begin
            gpi_meta_ff  <= gpi_pin;
            gpi_sync_ff  <= gpi_meta_ff;
            gpio_meta_ff <= gpio_in;
            gpio_sync_ff <= gpio_meta_ff;
        end
    end

    // bus-rate and real-time-rate tick dividers, both free running
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            bus_cnt_ff <= 12'h000;
            rtc_cnt_ff <= 12'h000;
        end else begin
            bus_cnt_ff <= (bus_cnt_ff == BUS_DIV - 12'h001) ? 12'h000 : bus_cnt_ff + 12'h001;
            rtc_cnt_ff <= (rtc_cnt_ff == RTC_DIV - 12'h001) ? 12'h000 : rtc_cnt_ff + 12'h001;
        end
    end

    assign bus_tick = (bus_cnt_ff == 12'h000);
    assign rtc_tick = (rtc_cnt_ff == 12'h000);

    // sleep slows sampling, so short pulses are only caught while awake
    assign sample_en = sleep_state ? rtc_tick : bus_tick;

    // blink phase runs off the real-time tick so it keeps going in sleep
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            blink_cnt_ff   <= 16'h0000;
            blink_phase_ff <= 1'b0;
        end else if (rtc_tick) begin
            if (blink_cnt_ff == BLINK_MAX) begin
                blink_cnt_ff   <= 16'h0000;
                blink_phase_ff <= ~blink_phase_ff;
            end else begin
                blink_cnt_ff <= blink_cnt_ff + 16'h0001;
            end
        end
    end

    // one qualifier per implemented input position; unimplemented positions stay idle
    genvar gi;
    generate
        for (gi = 0; gi < 14; gi = gi + 1) begin : g_in
            if (((`GPB_IN_MASK >> gi) & 1) != 0) begin : g_impl
                gpb_in_qual u_qual (
                    .ref_clk   (ref_clk),
                    .reset_n   (reset_n),
                    .sample_en (sample_en),
                    .pin_sync  (gpi_sync_ff[gi]),
                    .invert    (polarity_ff[gi]),
                    .qualified (qualified[gi])
                );
            end else begin : g_none
                assign qualified[gi] = 1'b0;
            end
        end
    endgenerate

    assign set_vec = {18'h0_0000, qualified} & `GPB_IN_MASK;

    // routing: one two-bit code per pin, so a pin cannot reach both outputs
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_route
            assign mgmt_vec[gi] = status_ff[gi] & (route_ff[2*gi+1:2*gi] == `GPB_ROUTE_MGMT);
            assign cfg_vec[gi]  = status_ff[gi] & (route_ff[2*gi+1:2*gi] == `GPB_ROUTE_CFG);
        end
    endgenerate

    assign management_interrupt    = |mgmt_vec;
    assign configuration_interrupt = |cfg_vec;
    assign irq                     = |(status_ff & irq_mask_ff);

    // write decode
    assign wr_sel   = reg_wr & (reg_addr == `GPB_OFS_FUNC_SELECT);
    assign wr_gc    = reg_wr & (reg_addr == `GPB_OFS_GEN_CONTROL);
    assign wr_pol   = reg_wr & (reg_addr == `GPB_OFS_POLARITY);
    assign wr_sts   = reg_wr & (reg_addr == `GPB_OFS_EVENT_STATUS);
    assign wr_lvl   = reg_wr & (reg_addr == `GPB_OFS_PIN_LEVEL);
    assign wr_blk   = reg_wr & (reg_addr == `GPB_OFS_BLINK_SELECT);
    assign wr_dir   = reg_wr & (reg_addr == `GPB_OFS_IO_DIRECTION);
    assign wr_route = reg_wr & (reg_addr == `GPB_OFS_ROUTE);
    assign wr_mask  = reg_wr & (reg_addr == `GPB_OFS_IRQ_MASK);

    // sticky status: set wins over a same-cycle clear, so an active input re-sets
    always @* begin
        nxt_status = status_ff;
        if (wr_sts) begin
            nxt_status = nxt_status & ~reg_wdata;
        end
        nxt_status = (nxt_status | set_vec) & `GPB_IN_MASK;
    end

    // control registers; only implemented bits can be written, save the route register, which takes every bit
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            func_select_ff <= `GPB_RST_FUNC_SELECT;
            gen_control_ff <= `GPB_RST_ZERO;
            polarity_ff    <= `GPB_RST_ZERO;
            status_ff      <= `GPB_RST_ZERO;
            level_ff       <= `GPB_RST_ZERO;
            blink_ff       <= `GPB_RST_ZERO;
            io_dir_ff      <= `GPB_RST_ZERO;
            route_ff       <= `GPB_RST_ZERO;
            irq_mask_ff    <= `GPB_RST_ZERO;
        end else begin
            status_ff <= nxt_status;
            if (wr_sel) begin
                func_select_ff <= reg_wdata & `GPB_SEL_MASK;
            end
            if (wr_gc) begin
                gen_control_ff <= reg_wdata & `GPB_GC_MASK;
            end
            if (wr_pol) begin
                polarity_ff <= reg_wdata & `GPB_IN_MASK;
            end
            if (wr_lvl) begin
                level_ff <= reg_wdata & `GPB_LEVEL_MASK;
            end
            if (wr_blk) begin
                blink_ff <= reg_wdata & `GPB_BLINK_MASK;
            end
            if (wr_dir) begin
                io_dir_ff <= reg_wdata & `GPB_BIDIR_MASK;
            end
            if (wr_route) begin
                route_ff <= reg_wdata;
            end
            if (wr_mask) begin
                irq_mask_ff <= reg_wdata & `GPB_IN_MASK;
            end
        end
    end

    // bidir positions read the sampled pin instead of the stored drive value
    assign level_rd = (level_ff & `GPB_OUT_MASK)
                    | ({3'b000, gpio_sync_ff[2], gpio_sync_ff[1], 1'b0, gpio_sync_ff[0], 25'h000_0000});

    // read mux, answered one cycle after the strobe; unmapped reads give zero
    always @* begin
        nxt_rdata = 32'h0000_0000;
        case (reg_addr)
            `GPB_OFS_FUNC_SELECT:  nxt_rdata = func_select_ff;
            `GPB_OFS_GEN_CONTROL:  nxt_rdata = gen_control_ff;
            `GPB_OFS_POLARITY:     nxt_rdata = polarity_ff;
            `GPB_OFS_EVENT_STATUS: nxt_rdata = status_ff;
            `GPB_OFS_PIN_LEVEL:    nxt_rdata = level_rd;
            `GPB_OFS_BLINK_SELECT: nxt_rdata = blink_ff;
            `GPB_OFS_IO_DIRECTION: nxt_rdata = io_dir_ff;
            `GPB_OFS_ROUTE:        nxt_rdata = route_ff;
            `GPB_OFS_IRQ_MASK:     nxt_rdata = irq_mask_ff;
            default:               nxt_rdata = 32'h0000_0000;
        endcase
    end

    // read data stands only in the cycle after the read strobe
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            rdata_ff <= 32'h0000_0000;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_ff;

    // request and interrupt alternates pass the synchronised pin, idle high otherwise
    assign bus_req_a_n = func_select_ff[0] ? gpi_sync_ff[0] : 1'b1;
    assign bus_req_b_n = (func_select_ff[1] & ~gen_control_ff[`GPB_GC_REQ5_BIT]) ? gpi_sync_ff[1] : 1'b1;
    assign bus_req_5_n = (func_select_ff[1] & gen_control_ff[`GPB_GC_REQ5_BIT]) ? gpi_sync_ff[1] : 1'b1;

    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_shint
            assign shared_interrupt_e_to_h_n[gi] = func_select_ff[gi+2] ? gpi_sync_ff[gi+2] : 1'b1;
        end
    endgenerate

    assign bus_alert_n = func_select_ff[`GPB_SEL_ALERT_BIT] ? gpi_sync_ff[11] : 1'b1;

    // output pins: grant in alternate mode, pin level bit otherwise
    assign gpo_pin[0] = func_select_ff[0] ? bus_grant_a_n : level_ff[`GPB_PIN_GNT_A];
    assign gpo_pin[1] = func_select_ff[1]
                      ? (gen_control_ff[`GPB_GC_REQ5_BIT] ? bus_grant_5_n : bus_grant_b_n)
                      : level_ff[`GPB_PIN_GNT_B];

    // bidirectional drive; blink forces the low half of each blink period
    assign gpio_out[0] = level_ff[`GPB_PIN_IO25] & ~(blink_ff[`GPB_PIN_IO25] & blink_phase_ff);
    assign gpio_out[1] = level_ff[`GPB_PIN_IO27];
    assign gpio_out[2] = level_ff[`GPB_PIN_IO28];
    assign gpio_oe[0]  = io_dir_ff[`GPB_PIN_IO25];
    assign gpio_oe[1]  = io_dir_ff[`GPB_PIN_IO27];
    assign gpio_oe[2]  = io_dir_ff[`GPB_PIN_IO28];

endmodule

// File: design/gpb_in_qual.v
`timescale 1ns/1ps
// polarity and two-sample qualifier for one already synchronised input
module gpb_in_qual (
    // clock and reset
    input  wire ref_clk,
    input  wire reset_n,
    // sampling
    input  wire sample_en,
    input  wire pin_sync,
    input  wire invert,
    // result
    output wire qualified
);

    reg prev_ff;
    reg qual_ff;
    wire active;

    // polarity bit chooses which level counts as active
    assign active = pin_sync ^ invert;

    // two consecutive sampling clocks must see the input active
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            prev_ff <= 1'b0;
            qual_ff <= 1'b0;
        end else if (sample_en) begin
            prev_ff <= active;
            qual_ff <= active & prev_ff;
        end
    end

    assign qualified = qual_ff;

endmodule

// File: design/gpb_regs.vh
`ifndef GPB_REGS_VH
`define GPB_REGS_VH

// register offsets, byte addresses on the plain register port
`define GPB_OFS_FUNC_SELECT   8'h00
`define GPB_OFS_GEN_CONTROL   8'h04
`define GPB_OFS_POLARITY      8'h08
`define GPB_OFS_EVENT_STATUS  8'h0C
`define GPB_OFS_PIN_LEVEL     8'h10
`define GPB_OFS_BLINK_SELECT  8'h14
`define GPB_OFS_IO_DIRECTION  8'h18
`define GPB_OFS_ROUTE         8'h1C
`define GPB_OFS_IRQ_MASK      8'h20

// implemented bit positions
`define GPB_IN_MASK           32'h0000_39BF
`define GPB_SEL_MASK          32'h0000_083F
`define GPB_OUT_MASK          32'h0003_0000
`define GPB_BIDIR_MASK        32'h1A00_0000
`define GPB_LEVEL_MASK        32'h1A03_0000
`define GPB_BLINK_MASK        32'h0200_0000
`define GPB_GC_MASK           32'h0200_0000

// field positions
`define GPB_GC_REQ5_BIT       25
`define GPB_PIN_GNT_A         16
`define GPB_PIN_GNT_B         17
`define GPB_PIN_IO25          25
`define GPB_PIN_IO27          27
`define GPB_PIN_IO28          28
`define GPB_SEL_ALERT_BIT     11

// reset values: every shared pin starts in its alternate function
`define GPB_RST_FUNC_SELECT   32'h0000_083F
`define GPB_RST_ZERO          32'h0000_0000

// route field codes, two bits per pin 0..15
`define GPB_ROUTE_MGMT        2'b01
`define GPB_ROUTE_CFG         2'b10

// timing
`define GPB_CLK_HZ            100000000
`define GPB_BUS_SAMPLE_HZ     33000000
`define GPB_RTC_SAMPLE_HZ     32768
`define GPB_BLINK_RTC_TICKS   16384

`endif

// File: dv/gpb_bank_sva.sv
`timescale 1ns/1ps
// port-level checks on the pin bank
module gpb_bank_sva (
    // clock and reset
    input wire        ref_clk,
    input wire        reset_n,
    // register port
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    // pins
    input wire [13:0] gpi_pin,
    input wire [2:0]  gpio_out,
    input wire [2:0]  gpio_oe,
    // alternate functions and interrupts
    input wire        bus_req_a_n,
    input wire        bus_req_b_n,
    input wire        bus_req_5_n,
    input wire [3:0]  shared_interrupt_e_to_h_n,
    input wire        bus_alert_n,
    input wire        management_interrupt,
    input wire        configuration_interrupt,
    input wire        irq
);
    reg [1:0] settle_ff;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // pin checks wait until the synchroniser holds only post-reset samples
    always @(posedge ref_clk) begin
        if (!reset_n)
            settle_ff <= 2'h0;
        else if (settle_ff != 2'h3)
            settle_ff <= settle_ff + 2'h1;
    end

    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside reply cycle");
    AST_REQ_A: assert property (settle_ff == 2'h3 && !bus_req_a_n |-> !$past(gpi_pin[0], 2))
        else $error("request a low without pin 0 low");
    AST_REQ_B_5: assert property (settle_ff == 2'h3 && !(bus_req_b_n && bus_req_5_n)
        |-> bus_req_b_n != bus_req_5_n && !$past(gpi_pin[1], 2)) else $error("request b or 5 wrong");
    AST_SHARED: assert property (settle_ff == 2'h3
        |-> (~shared_interrupt_e_to_h_n & $past(gpi_pin[5:2], 2)) == 4'h0) else $error("shared line low");
    AST_ALERT: assert property (settle_ff == 2'h3 && !bus_alert_n |-> !$past(gpi_pin[11], 2))
        else $error("alert low without pin 11 low");
    AST_BIDIR: assert property ($changed({gpio_oe, gpio_out[2:1]}) |-> $past(reg_wr))
        else $error("two-way drive changed without a write");
    AST_STICKY: assert property ($fell(irq) |-> $past(reg_wr))
        else $error("interrupt dropped without a write");
    AST_ROUTE: assert property ($fell(management_interrupt) || $fell(configuration_interrupt)
        |-> $past(reg_wr)) else $error("routed interrupt dropped without a write");
endmodule

bind gpb_bank gpb_bank_sva u_sva (
    .ref_clk, .reset_n, .reg_wr, .reg_rd, .reg_rdata, .gpi_pin, .gpio_out, .gpio_oe,
    .bus_req_a_n, .bus_req_b_n, .bus_req_5_n, .shared_interrupt_e_to_h_n, .bus_alert_n,
    .management_interrupt, .configuration_interrupt, .irq
);

// File: dv/gpb_bank_tb.sv
`timescale 1ns/1ps
`include "gpb_regs.vh"
module gpb_bank_tb;
    // clock, reset and register port
    reg         ref_clk;
    reg         reset_n = 1'b0;
    reg  [7:0]  reg_addr = 8'h00;
    reg  [31:0] reg_wdata = 32'h0000_0000;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    wire [31:0] reg_rdata;
    // board side and grants
    reg         sleep_state = 1'b0;
    reg  [13:0] gpi_level = 14'h0000;
    reg  [2:0]  io_level = 3'h0;
    reg         bus_grant_a_n = 1'b0;
    reg         bus_grant_b_n = 1'b1;
    reg         bus_grant_5_n = 1'b0;
    wire [13:0] gpi_pin;
    wire [1:0]  gpo_pin;
    wire [2:0]  gpio_in, gpio_out, gpio_oe;
    wire        bus_req_a_n, bus_req_b_n, bus_req_5_n, bus_alert_n;
    wire [3:0]  shared_interrupt_e_to_h_n;
    wire        management_interrupt, configuration_interrupt, irq;
    wire [7:0]  alt = {bus_req_a_n, bus_req_b_n, bus_req_5_n, shared_interrupt_e_to_h_n, bus_alert_n};
    wire [31:0] irqs = {29'h0000_0000, irq, management_interrupt, configuration_interrupt};
    // bookkeeping
    integer     n_fail = 0;
    integer     samples_checked = 0;
    integer     i;
    integer     tg;
    reg         prv;

    // blink half period cut to two real-time ticks to keep the run short
    gpb_bank #(.BLINK_TICKS(2)) dut (
        .ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_state,
        .gpi_pin, .gpo_pin, .gpio_in, .gpio_out, .gpio_oe, .bus_req_a_n, .bus_req_b_n, .bus_req_5_n,
        .bus_grant_a_n, .bus_grant_b_n, .bus_grant_5_n, .shared_interrupt_e_to_h_n, .bus_alert_n,
        .management_interrupt, .configuration_interrupt, .irq
    );
    gpb_pins board (.gpi_level, .io_level, .gpio_out, .gpio_oe, .gpi_pin, .gpio_in);

    // 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task chk(input [31:0] got, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask

    // look one step after the edge so its updates have landed
    task cyc(input integer n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task pins(input [13:0] v);
        @(posedge ref_clk);
        gpi_level <= v;
    endtask

    // every access starts on a fresh edge, so strobes are never assigned twice in one step
    task wr(input [7:0] a, input [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input [7:0] a, input [31:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    // shared functions out of reset, then plain outputs once deselected
    task t_alt;
        chk({30'h0000_0000, gpo_pin}, 32'h0000_0002);
        rd(`GPB_OFS_FUNC_SELECT, `GPB_RST_FUNC_SELECT);
        rd(8'h24, 32'h0000_0000);
        pins(14'h0028);
        cyc(4);
        chk(alt, 32'h0000_0034);
        wr(`GPB_OFS_GEN_CONTROL, 32'hFFFF_FFFF);
        bus_grant_a_n <= 1'b1;  // grants now differ, so a swapped grant shows up
        cyc(1);
        chk({bus_req_b_n, bus_req_5_n, gpo_pin}, 32'h0000_0009);
        rd(`GPB_OFS_GEN_CONTROL, `GPB_GC_MASK);
        wr(`GPB_OFS_FUNC_SELECT, 32'h0000_0000);
        wr(`GPB_OFS_PIN_LEVEL, 32'h0002_0000);
        cyc(1);
        chk({alt, gpo_pin}, 32'h0000_03FE);
    endtask

    // sticky level status: polarity, re-set while active, write-one-clear, two-sample qualifier
    task t_status;
        pins(14'h0000);
        wr(`GPB_OFS_POLARITY, 32'hFFFF_FFFF);
        cyc(20);
        wr(`GPB_OFS_EVENT_STATUS, 32'hFFFF_FFFF);
        rd(`GPB_OFS_EVENT_STATUS, `GPB_IN_MASK);
        wr(`GPB_OFS_POLARITY, 32'h0000_0000);
        cyc(12);
        wr(`GPB_OFS_EVENT_STATUS, 32'h0000_0000);
        rd(`GPB_OFS_EVENT_STATUS, `GPB_IN_MASK);
        wr(`GPB_OFS_EVENT_STATUS, 32'hFFFF_FFFF);
        rd(`GPB_OFS_EVENT_STATUS, 32'h0000_0000);
        pins(14'h0080);
        pins(14'h0000);
        cyc(12);
        rd(`GPB_OFS_EVENT_STATUS, 32'h0000_0000);
        pins(14'h0080);
        cyc(8);
        pins(14'h0000);
        cyc(12);
        rd(`GPB_OFS_EVENT_STATUS, 32'h0000_0080);
    endtask

    // pin 7 status, unmasked first, through route codes 1 to 3, then cleared
    task t_irq;
        wr(`GPB_OFS_IRQ_MASK, 32'h0000_0080);
        for (i = 1; i < 4; i = i + 1) begin
            wr(`GPB_OFS_ROUTE, i << 14);
            cyc(2);
            chk(irqs, {29'h0000_0000, 1'b1, i == 1, i == 2});
        end
        wr(`GPB_OFS_EVENT_STATUS, 32'h0000_0080);
        cyc(2);
        chk(irqs, 32'h0000_0000);
    endtask

    // asleep, a 20-cycle level sees at most one sample; a long one is caught
    task t_sleep;
        @(posedge ref_clk);
        sleep_state <= 1'b1;
        pins(14'h1000);
        cyc(20);
        pins(14'h0000);
        cyc(12);
        rd(`GPB_OFS_EVENT_STATUS, 32'h0000_0000);
        pins(14'h1000);
        cyc(6400);
        pins(14'h0000);
        cyc(12);
        rd(`GPB_OFS_EVENT_STATUS, 32'h0000_1000);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        @(posedge ref_clk);
        sleep_state <= 1'b0;
    endtask

    // two-way pins: drive and read back, read the board when released, then blink pin 25
    task t_bidir;
        wr(`GPB_OFS_IO_DIRECTION, `GPB_BIDIR_MASK);
        wr(`GPB_OFS_PIN_LEVEL, 32'h1000_0000);
        cyc(4);
        chk({gpio_oe, gpio_out}, 32'h0000_003C);
        rd(`GPB_OFS_PIN_LEVEL, 32'h1000_0000);
        @(posedge ref_clk);
        io_level <= 3'h3;
        wr(`GPB_OFS_IO_DIRECTION, 32'h0000_0000);
        cyc(4);
        rd(`GPB_OFS_PIN_LEVEL, 32'h0A00_0000);
        wr(`GPB_OFS_IO_DIRECTION, 32'h0200_0000);
        wr(`GPB_OFS_PIN_LEVEL, 32'h0200_0000);
        wr(`GPB_OFS_BLINK_SELECT, 32'h0200_0000);
        cyc(2);
        tg = 0;
        prv = gpio_out[0];
        repeat (14000) begin
            cyc(1);
            tg = tg + (gpio_out[0] !== prv);
            prv = gpio_out[0];
        end
        chk({31'h0000_0000, tg == 2 || tg == 3}, 32'h0000_0001);
    endtask

    task close_out;
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // reset for three cycles, then the scenarios in turn
    initial begin
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        cyc(1);
        t_alt;
        t_status;
        t_irq;
        t_sleep;
        t_bidir;
        close_out;
    end

    // hang guard, well past the roughly 20600 cycles the scenarios need
    initial begin
        repeat (60000) @(posedge ref_clk);
        n_fail = n_fail + 1;
        close_out;
    end
endmodule

// File: dv/gpb_pins.sv
`timescale 1ns/1ps
// board devices: input pins always driven, two-way pins only while the bank lets go
module gpb_pins (
    // levels the bench asks the board to present
    input  wire [13:0] gpi_level,
    input  wire [2:0]  io_level,
    // bank side of the two-way pins
    input  wire [2:0]  gpio_out,
    input  wire [2:0]  gpio_oe,
    // levels the bank sees
    output wire [13:0] gpi_pin,
    output wire [2:0]  gpio_in
);
    // the bank wins on an enabled pin, otherwise the board device drives it
    assign gpi_pin = gpi_level;
    assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & io_level);
endmodule
